/* File: hw/fpm_ctrl.sv */
/*
 Front panel menu controller: debounces four buttons and runs the power-up,
 auto-scroll, main menu, reset, password and configuration screens.
 Assumes buttons are raw active-high pins, a display driver that renders the
 screen code, and metering logic that acts on the clear and reboot pulses.
*/
`timescale 1ns/1ps
module fpm_ctrl #(
  parameter int unsigned SHOW_CYCLES = fpm_pkg::SHOW_CYC,
  parameter int unsigned PAUSE_CYCLES = fpm_pkg::PAUSE_CYC,
  parameter longint unsigned HOLD_CYCLES = fpm_pkg::HOLD_CYC,
  parameter int unsigned STARTUP_CYCLES = fpm_pkg::STARTUP_CYC,
  parameter int unsigned MSG_CYCLES = fpm_pkg::MSG_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = fpm_pkg::DEBOUNCE_CYC,
  parameter int unsigned N_PARAMS = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire fpm_pkg::fpm_btn_t btn_pin,
  input wire logic error_present,
  input wire logic pass_reset_en,
  input wire logic pass_cfg_en,
  input wire logic [15:0] password,
  input wire logic ct_den_one_amp,
  output fpm_pkg::fpm_disp_t disp,
  output logic lamp_all_on,
  output logic [7:0] param_sel,
  output fpm_pkg::fpm_cfg_t cfg_stored,
  output logic [3:0] ct_den_amps,
  output logic [23:0] ct_primary,
  output logic clear_maxmin,
  output logic reboot
);
  import fpm_pkg::*;

  typedef enum logic [1:0] {PW_NONE, PW_RESET, PW_CFG} fpm_pw_t;

  // Synchroniser and debounce: three stages, the last two must agree.
  logic [3:0] s1_r, s2_r, s3_r, stable_r, prev_r;
  logic [31:0] db_cnt_r;
  wire [3:0] raw_w = {btn_pin.menu, btn_pin.enter, btn_pin.down, btn_pin.right};
  wire agree_w = (s2_r == s3_r);
  wire db_done_w = (db_cnt_r >= DEBOUNCE_CYCLES - 1);
  wire [3:0] press_w = stable_r & ~prev_r;
  fpm_btn_t ev;
  assign ev = press_w;
  wire any_w = |press_w;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
      stable_r <= 4'h0;
      prev_r <= 4'h0;
      db_cnt_r <= 32'h0;
    end else begin
      s1_r <= raw_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      prev_r <= stable_r;
      // A held button stays stable, so it gives only one rising event.
      if (!agree_w || s3_r == stable_r) db_cnt_r <= 32'h0;
      else if (db_done_w) begin
        stable_r <= s3_r;
        db_cnt_r <= 32'h0;
      end else db_cnt_r <= db_cnt_r + 32'h1;
    end
  end

  // Main state.
  fpm_screen_t scr_r, scr_nxt, ret_r, ret_nxt;
  fpm_pw_t pw_r, pw_nxt;
  logic [1:0] mode_r, mode_nxt, dpos_r, dpos_nxt;
  logic [2:0] csel_r, csel_nxt;
  logic [15:0] dig_r, dig_nxt;
  logic [1:0] menus_r, menus_nxt;
  logic cfg_ok_r, cfg_ok_nxt;
  fpm_cfg_t work_r, work_nxt, stored_r;
  logic save_r, save_nxt, clr_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [32:0] hold_r;
  logic [7:0] psel_r, psel_nxt;
  logic [23:0] flash_r;

  // Digit step 0..9 on the selected BCD nibble.
  function automatic logic [15:0] step_digit(input logic [15:0] v, input logic [1:0] pos);
    logic [3:0] n;
    logic [15:0] r;
    n = v[4'(12 - 4 * pos) +: 4];
    r = v;
    r[4'(12 - 4 * pos) +: 4] = (n >= 4'h9) ? 4'h0 : n + 4'h1;
    return r;
  endfunction : step_digit

  wire tmr_done_w = (tmr_r == 32'h0);
  wire hold_act_w = (hold_r != 33'h0);
  wire pass_ok_w = (dig_r == password);

  always_comb begin
    scr_nxt = scr_r;
    ret_nxt = ret_r;
    pw_nxt = pw_r;
    mode_nxt = mode_r;
    dpos_nxt = dpos_r;
    csel_nxt = csel_r;
    dig_nxt = dig_r;
    menus_nxt = 2'h0;
    cfg_ok_nxt = cfg_ok_r;
    work_nxt = work_r;
    save_nxt = 1'b0;
    clr_nxt = 1'b0;
    psel_nxt = psel_r;
    tmr_nxt = tmr_done_w ? 32'h0 : tmr_r - 32'h1;
    unique case (scr_r)
      // Power-up sequence, each screen timed.
      SCR_LAMP_LED: if (tmr_done_w) begin
        scr_nxt = SCR_LAMP_SEG;
        tmr_nxt = STARTUP_CYCLES;
      end
      SCR_LAMP_SEG: if (tmr_done_w) begin
        scr_nxt = SCR_BUILD;
        tmr_nxt = STARTUP_CYCLES;
      end
      SCR_BUILD: if (tmr_done_w) begin
        scr_nxt = error_present ? SCR_ERROR : SCR_READING;
        tmr_nxt = error_present ? STARTUP_CYCLES : SHOW_CYCLES;
      end
      SCR_ERROR: if (tmr_done_w) begin
        scr_nxt = SCR_READING;
        tmr_nxt = SHOW_CYCLES;
      end
      // Seven seconds shown, one second blank, unless held off.
      SCR_READING, SCR_BLANK: begin
        if (ev.menu) begin
          scr_nxt = SCR_MAIN;
          mode_nxt = 2'h0;
        end else if (ev.down) psel_nxt = (psel_r >= 8'(N_PARAMS - 1)) ? 8'h0 : psel_r + 8'h1;
        else if (!stored_r.scroll_en || hold_act_w) tmr_nxt = SHOW_CYCLES;
        else if (tmr_done_w && scr_r == SCR_READING) begin
          scr_nxt = SCR_BLANK;
          tmr_nxt = PAUSE_CYCLES;
        end else if (tmr_done_w) begin
          scr_nxt = SCR_READING;
          tmr_nxt = SHOW_CYCLES;
          psel_nxt = (psel_r >= 8'(N_PARAMS - 1)) ? 8'h0 : psel_r + 8'h1;
        end
        if (any_w) scr_nxt = ev.menu ? SCR_MAIN : SCR_READING;
      end
      SCR_MAIN: begin
        if (ev.down) mode_nxt = mode_r + 2'h1;
        else if (ev.menu) scr_nxt = SCR_READING;
        else if (ev.enter) begin
          // Enter opens the flashing mode.
          unique case (mode_r)
            2'h0: scr_nxt = SCR_RST_NO;
            2'h1: begin
              scr_nxt = SCR_CFG_LIST;
              csel_nxt = 3'h0;
              work_nxt = stored_r;
              cfg_ok_nxt = 1'b0;
            end
            2'h2: scr_nxt = SCR_READING;
            2'h3: scr_nxt = SCR_MODEL_DETAILS_ENTRY;
          endcase
        end
      end
      SCR_RST_NO: begin
        if (ev.enter) begin
          scr_nxt = SCR_MAIN;
          mode_nxt = 2'h1;
        end else if (ev.right) scr_nxt = SCR_RST_YES;
        else if (ev.menu) scr_nxt = SCR_MAIN;
      end
      SCR_RST_YES: begin
        if (ev.enter && pass_reset_en) begin
          scr_nxt = SCR_PASS;
          pw_nxt = PW_RESET;
          ret_nxt = SCR_RST_YES;
          dig_nxt = 16'h0;
          dpos_nxt = 2'h0;
        end else if (ev.enter) begin
          clr_nxt = 1'b1;
          scr_nxt = SCR_RST_DONE;
          tmr_nxt = MSG_CYCLES;
        end else if (ev.right) scr_nxt = SCR_RST_NO;
        else if (ev.menu) scr_nxt = SCR_MAIN;
      end
      SCR_RST_DONE, SCR_PASS_FAIL: if (tmr_done_w) begin
        scr_nxt = (scr_r == SCR_RST_DONE) ? SCR_READING : ret_r;
        tmr_nxt = SHOW_CYCLES;
      end
      SCR_PASS: begin
        if (ev.down) dig_nxt = step_digit(dig_r, dpos_r);
        else if (ev.right) dpos_nxt = dpos_r + 2'h1;
        else if (ev.enter && pass_ok_w) begin
          if (pw_r == PW_RESET) begin
            clr_nxt = 1'b1;
            scr_nxt = SCR_RST_DONE;
            tmr_nxt = MSG_CYCLES;
          end else begin
            cfg_ok_nxt = 1'b1;
            scr_nxt = ret_r;
            dpos_nxt = 2'h0; // The edit that asked for the code began at the leftmost digit.
          end
          pw_nxt = PW_NONE;
        end else if (ev.enter) begin
          scr_nxt = SCR_PASS_FAIL;
          tmr_nxt = MSG_CYCLES;
          if (pw_r == PW_CFG) ret_nxt = SCR_READING;
          pw_nxt = PW_NONE;
        end
      end
      // Parameter list of configuration mode.
      SCR_CFG_LIST: begin
        if (ev.down) csel_nxt = (csel_r >= 3'(N_CFG - 1)) ? 3'h0 : csel_r + 3'h1;
        else if (ev.enter) begin
          unique case (csel_r)
            3'h0: scr_nxt = SCR_SCROLL_SET;
            3'h1: scr_nxt = SCR_CT_NUM;
            default: scr_nxt = SCR_OTHER_SET;
          endcase
          dpos_nxt = 2'h0;
        end else if (ev.menu) scr_nxt = SCR_MAIN;
      end
      SCR_SCROLL_SET, SCR_CT_NUM, SCR_CT_DEN, SCR_CT_MULT, SCR_OTHER_SET: begin
        // Editing first asks for the password when protection is on.
        if ((ev.down || ev.right) && pass_cfg_en && !cfg_ok_r) begin
          scr_nxt = SCR_PASS;
          pw_nxt = PW_CFG;
          ret_nxt = scr_r;
          dig_nxt = 16'h0;
          dpos_nxt = 2'h0;
        end else if (ev.down || ev.right) begin
          unique case (scr_r)
            SCR_SCROLL_SET: work_nxt.scroll_en = ~work_r.scroll_en;
            SCR_CT_NUM: if (ev.down) work_nxt.ct_num = step_digit(work_r.ct_num, dpos_r);
              else dpos_nxt = dpos_r + 2'h1;
            SCR_CT_MULT: work_nxt.ct_mult = (work_r.ct_mult >= MULT_MAX) ? 2'h0 : work_r.ct_mult + 2'h1;
            default: ; // Denominator is fixed; other settings live elsewhere.
          endcase
        end else if (ev.enter) begin
          // Enter walks the settings in order, wrapping to the list.
          dpos_nxt = 2'h0;
          unique case (scr_r)
            SCR_SCROLL_SET: scr_nxt = SCR_CT_NUM;
            SCR_CT_NUM: scr_nxt = SCR_CT_DEN;
            SCR_CT_DEN: scr_nxt = SCR_CT_MULT;
            SCR_CT_MULT: begin
              scr_nxt = SCR_CFG_LIST;
              csel_nxt = 3'h2;
            end
            default: begin
              scr_nxt = SCR_CFG_LIST;
              csel_nxt = (csel_r >= 3'(N_CFG - 1)) ? 3'h0 : csel_r + 3'h1;
            end
          endcase
        end else if (ev.menu) begin
          // First menu leaves the setting; a second asks to store if the settings were edited, else returns to the main menu.
          if (work_r != stored_r) scr_nxt = SCR_CFG_LIST;
          else scr_nxt = SCR_CFG_LIST;
          menus_nxt = 2'h1;
        end
      end
      default: ;
    endcase
    // Menu counting after a setting screen, shared by list and main menu.
    if (scr_r == SCR_CFG_LIST && ev.menu && menus_r == 2'h1) begin
      scr_nxt = (work_r != stored_r) ? SCR_STORE_YES : SCR_MAIN;
      menus_nxt = 2'h2;
    end else if (scr_r == SCR_CFG_LIST && !any_w) menus_nxt = menus_r;
    if (scr_r == SCR_MAIN && ev.menu && menus_r == 2'h2) scr_nxt = SCR_READING;
    else if (scr_r == SCR_MAIN && !any_w) menus_nxt = menus_r;
    unique case (scr_r)
      SCR_STORE_YES: if (ev.enter) begin
        save_nxt = 1'b1;
        scr_nxt = SCR_STORE_DONE;
        tmr_nxt = MSG_CYCLES;
      end else if (ev.right) scr_nxt = SCR_STORE_NO;
      SCR_STORE_NO: if (ev.enter) begin
        work_nxt = stored_r;
        scr_nxt = SCR_MAIN;
      end else if (ev.right) scr_nxt = SCR_STORE_YES;
      SCR_STORE_DONE: if (tmr_done_w) begin
        scr_nxt = SCR_LAMP_LED; // Restart sequence after save.
        tmr_nxt = STARTUP_CYCLES;
      end
      SCR_MODEL_DETAILS_ENTRY: if (ev.menu || ev.enter) scr_nxt = SCR_MAIN;
      default: ;
    endcase
  end

  // State registers; the power-up sequence starts at reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scr_r <= SCR_LAMP_LED;
      ret_r <= SCR_READING;
      pw_r <= PW_NONE;
      mode_r <= 2'h0;
      dpos_r <= 2'h0;
      csel_r <= 3'h0;
      dig_r <= 16'h0;
      menus_r <= 2'h0;
      cfg_ok_r <= 1'b0;
      work_r <= {RST_SCROLL_EN, RST_CT_NUM, RST_CT_MULT};
      save_r <= 1'b0;
      clear_maxmin <= 1'b0;
      tmr_r <= STARTUP_CYCLES;
      psel_r <= 8'h0;
    end else begin
      scr_r <= scr_nxt;
      ret_r <= ret_nxt;
      pw_r <= pw_nxt;
      mode_r <= mode_nxt;
      dpos_r <= dpos_nxt;
      csel_r <= csel_nxt;
      dig_r <= dig_nxt;
      menus_r <= menus_nxt;
      cfg_ok_r <= cfg_ok_nxt;
      work_r <= work_nxt;
      save_r <= save_nxt;
      clear_maxmin <= clr_nxt;
      tmr_r <= tmr_nxt;
      psel_r <= psel_nxt;
    end
  end

  // Stored settings only move on a confirmed save; reboot follows store-done.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stored_r <= {RST_SCROLL_EN, RST_CT_NUM, RST_CT_MULT};
      reboot <= 1'b0;
    end else begin
      if (save_r) stored_r <= work_r;
      reboot <= (scr_r == SCR_STORE_DONE) && tmr_done_w;
    end
  end

  // Hold-off after any press keeps scrolling parked for three minutes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hold_r <= 33'h0;
    else if (any_w) hold_r <= 33'(HOLD_CYCLES);
    else if (hold_act_w) hold_r <= hold_r - 33'h1;
  end

  // Flasher for the active entry and digit, about 1.5 Hz at 25 MHz. It restarts on every screen or
  // mode change, so a newly entered screen or mode is lit at once instead of possibly dark for a third of a second.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) flash_r <= 24'h0;
    else if (scr_nxt != scr_r || mode_nxt != mode_r) flash_r <= 24'h0;
    else flash_r <= flash_r + 24'h1;
  end

  // Rating as numerator (BCD) times multiplier.
  wire [15:0] num_bin_w = 16'(cfg_stored.ct_num[15:12] * 1000 + cfg_stored.ct_num[11:8] * 100 +
                              cfg_stored.ct_num[7:4] * 10 + cfg_stored.ct_num[3:0]);
  wire [23:0] mult_w = (cfg_stored.ct_mult == 2'h2) ? 24'h64 : (cfg_stored.ct_mult == 2'h1) ? 24'ha : 24'h1;
  wire [47:0] prod_w = {32'h0, num_bin_w} * {24'h0, mult_w};

  // Display and status outputs.
  assign cfg_stored = stored_r;
  assign ct_primary = prod_w[23:0];
  assign ct_den_amps = ct_den_one_amp ? 4'h1 : 4'h5;
  assign lamp_all_on = (scr_r == SCR_LAMP_LED);
  assign param_sel = psel_r;
  assign disp.screen = scr_r;
  assign disp.mode_sel = mode_r;
  assign disp.cfg_sel = csel_r;
  assign disp.digit_pos = dpos_r;
  assign disp.digits = (scr_r == SCR_PASS) ? dig_r : work_r.ct_num;
  assign disp.flash_upper = !flash_r[23] && (scr_r == SCR_MAIN || scr_r == SCR_CFG_LIST);
  assign disp.flash_digit = !flash_r[23] && (scr_r == SCR_PASS || scr_r == SCR_CT_NUM);

endmodule : fpm_ctrl

/* File: hw/fpm_pkg.sv */
/*
 Package for the front panel menu controller: timing constants, screen codes,
 setting carriers and reset values.
 Assumes a 25 MHz system clock; every module that uses it imports it whole.
*/
package fpm_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SHOW_S = 7;
  localparam int unsigned PAUSE_S = 1;
  localparam int unsigned HOLD_MIN = 3;
  localparam int unsigned STARTUP_MS = 1000;
  localparam int unsigned MSG_MS = 1000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned SHOW_CYC = SHOW_S * CLK_HZ;
  localparam int unsigned PAUSE_CYC = PAUSE_S * CLK_HZ;
  // Three minutes at 25 MHz does not fit in 32 bits, so this count is 64-bit.
  localparam longint unsigned HOLD_CYC = longint'(HOLD_MIN) * 60 * CLK_HZ;
  localparam int unsigned STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
  localparam int unsigned MSG_CYC = MSG_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);

  localparam int unsigned N_MODES = 4;
  localparam int unsigned N_CFG = 5;
  localparam int unsigned N_DIGITS = 4;

  // Reset values of the working and stored settings.
  localparam logic RST_SCROLL_EN = 1'b1;
  localparam logic [15:0] RST_CT_NUM = 16'h0200;
  localparam logic [1:0] RST_CT_MULT = 2'h0;

  // Multiplier codes: 0 is x1, 1 is x10, 2 is x100.
  localparam logic [1:0] MULT_MAX = 2'h2;

  typedef enum logic [5:0] {
    SCR_LAMP_LED, SCR_LAMP_SEG, SCR_BUILD, SCR_ERROR, SCR_READING, SCR_BLANK,
    SCR_MAIN, SCR_RST_NO, SCR_RST_YES, SCR_RST_DONE, SCR_PASS, SCR_PASS_FAIL,
    SCR_CFG_LIST, SCR_SCROLL_SET, SCR_CT_NUM, SCR_CT_DEN, SCR_CT_MULT,
    SCR_STORE_YES, SCR_STORE_NO, SCR_STORE_DONE, SCR_MODEL_DETAILS_ENTRY, SCR_OTHER_SET
  } fpm_screen_t;

  // Buttons, as raw pin levels or as one-cycle press events.
  typedef struct packed {
    logic menu;
    logic enter;
    logic down;
    logic right;
  } fpm_btn_t;

  // Settings edited from the panel; digits are BCD, most significant first.
  typedef struct packed {
    logic scroll_en;
    logic [15:0] ct_num;
    logic [1:0] ct_mult;
  } fpm_cfg_t;

  // What the display driver shows.
  typedef struct packed {
    fpm_screen_t screen;
    logic [1:0] mode_sel;
    logic [2:0] cfg_sel;
    logic [1:0] digit_pos;
    logic [15:0] digits;
    logic flash_upper;
    logic flash_digit;
  } fpm_disp_t;

endpackage : fpm_pkg

/* File: tb/fpm_ctrl_sva.sv */
/*
 Checker for the front panel menu controller, bound to its top module.
 Assumes the shortened timer parameters and one clock with async reset.
*/
`timescale 1ns/1ps
module fpm_ctrl_sva
  import fpm_pkg::*;
#(
  parameter int unsigned SHOW_CYCLES = 20,
  parameter int unsigned N_PARAMS = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire fpm_pkg::fpm_disp_t disp,
  input wire logic lamp_all_on,
  input wire logic [7:0] param_sel,
  input wire fpm_pkg::fpm_cfg_t cfg_stored,
  input wire logic ct_den_one_amp,
  input wire logic [3:0] ct_den_amps,
  input wire logic [23:0] ct_primary,
  input wire logic clear_maxmin,
  input wire logic reboot
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [31:0] dwell_r;
  logic [31:0] dwell_nxt;
  fpm_screen_t screen_r;
  logic [23:0] scale;
  logic [23:0] rating;

  function automatic logic [23:0] bcd_val(input logic [15:0] b);
    return 24'(b[15:12]) * 24'd1000 + 24'(b[11:8]) * 24'd100 + 24'(b[7:4]) * 24'd10 + 24'(b[3:0]);
  endfunction : bcd_val

  // Expected rating from the stored settings; code 3 never occurs, so it maps to x1.
  assign scale = (cfg_stored.ct_mult == 2'h2) ? 24'd100 : (cfg_stored.ct_mult == 2'h1) ? 24'd10 : 24'd1;
  assign rating = bcd_val(cfg_stored.ct_num) * scale;
  assign dwell_nxt = (disp.screen == screen_r) ? dwell_r + 32'h1 : 32'h1;

  // Counts cycles on one screen, since dwell figures exceed what a repetition may unroll.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dwell_r <= 32'h0;
      screen_r <= SCR_LAMP_LED;
    end else begin
      dwell_r <= dwell_nxt;
      screen_r <= disp.screen;
    end
  end

  sequence s_led_end;
    (disp.screen == SCR_LAMP_LED) ##1 (disp.screen != SCR_LAMP_LED);
  endsequence
  sequence s_seg_end;
    (disp.screen == SCR_LAMP_SEG) ##1 (disp.screen != SCR_LAMP_SEG);
  endsequence
  sequence s_show_end;
    (disp.screen == SCR_READING) ##1 (disp.screen == SCR_BLANK);
  endsequence
  sequence s_next_reading;
    (disp.screen == SCR_BLANK) ##1 (disp.screen == SCR_READING);
  endsequence

  property p_lamp; lamp_all_on == (disp.screen == SCR_LAMP_LED); endproperty
  property p_led_seg; s_led_end |-> disp.screen == SCR_LAMP_SEG; endproperty
  property p_seg_build; s_seg_end |-> disp.screen == SCR_BUILD; endproperty
  property p_show; s_show_end |-> dwell_r >= SHOW_CYCLES; endproperty
  property p_step; s_next_reading |-> param_sel == 8'((32'($past(param_sel)) + 1) % N_PARAMS); endproperty
  property p_den; ct_den_amps == (ct_den_one_amp ? 4'h1 : 4'h5); endproperty
  property p_rating; $stable(cfg_stored) |-> ct_primary == rating; endproperty
  property p_clear; clear_maxmin |=> !clear_maxmin && disp.screen == SCR_RST_DONE; endproperty
  property p_reboot; reboot |=> !reboot && disp.screen == SCR_LAMP_LED; endproperty
  property p_keep; !$stable(cfg_stored) |-> disp.screen == SCR_STORE_DONE; endproperty

  a_lamp: assert property (p_lamp) else $error("lamp output off its screen");
  a_led_seg: assert property (p_led_seg) else $error("segment test missing");
  a_seg_build: assert property (p_seg_build) else $error("build screen missing");
  a_show: assert property (p_show) else $error("reading shown too briefly");
  a_step: assert property (p_step) else $error("reading index not advanced");
  a_den: assert property (p_den) else $error("denominator wrong");
  a_rating: assert property (p_rating) else $error("primary rating wrong");
  a_clear: assert property (p_clear) else $error("clear pulse wrong");
  a_reboot: assert property (p_reboot) else $error("reboot pulse wrong");
  a_keep: assert property (p_keep) else $error("stored settings changed without save");
endmodule : fpm_ctrl_sva

/* File: tb/fpm_operator.sv */
/*
 Model of the operator at the panel: presses one button at a time.
 Assumes the bench calls push from one thread; pins move at the falling edge.
*/
`timescale 1ns/1ps
module fpm_operator
  import fpm_pkg::*;
(
  input wire logic clk,
  output fpm_pkg::fpm_btn_t btn_pin
);
  logic [3:0] pins_r = 4'h0;

  // Released buttons read low through the panel pull-downs.
  assign btn_pin = fpm_btn_t'(pins_r);

  // Hold one button, then stay released well past the debounce time so the
  // next press counts as a new event.
  task automatic push(input int b, input int hold);
    @(negedge clk);
    pins_r[b] = 1'b1;
    repeat (hold) @(negedge clk);
    pins_r[b] = 1'b0;
    repeat (8) @(negedge clk);
  endtask : push
endmodule : fpm_operator

/* File: tb/tb.sv */
/*
 Self-checking bench for the front panel menu controller.
 Assumes shortened timers; the operator model presses the buttons.
*/
`timescale 1ns/1ps
module tb;
  import fpm_pkg::*;
  localparam int MENU = 3;
  localparam int ENTER = 2;
  localparam int DOWN = 1;
  localparam int RIGHT = 0;
  logic clk, resetn, error_present, pass_reset_en, pass_cfg_en, ct_den_one_amp;
  logic lamp_all_on, clear_maxmin, reboot;
  logic [15:0] password;
  logic [7:0] param_sel;
  logic [3:0] ct_den_amps;
  logic [23:0] ct_primary;
  logic [63:0] seen;
  fpm_btn_t btn_pin;
  fpm_disp_t disp;
  fpm_cfg_t cfg_stored;
  int bad_count = 0;
  int checks_done = 0;
  int clears = 0;
  int reboots = 0;
  int p;

  fpm_ctrl #(.SHOW_CYCLES(20), .PAUSE_CYCLES(5), .STARTUP_CYCLES(5),
    .MSG_CYCLES(5), .DEBOUNCE_CYCLES(2)) dut_u (
    .clk(clk), .resetn(resetn), .btn_pin(btn_pin), .error_present(error_present),
    .pass_reset_en(pass_reset_en), .pass_cfg_en(pass_cfg_en), .password(password),
    .ct_den_one_amp(ct_den_one_amp), .disp(disp), .lamp_all_on(lamp_all_on), .param_sel(param_sel),
    .cfg_stored(cfg_stored), .ct_den_amps(ct_den_amps), .ct_primary(ct_primary),
    .clear_maxmin(clear_maxmin), .reboot(reboot));
  fpm_operator op_u (.clk(clk), .btn_pin(btn_pin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Short screens pass between presses, so every screen shown is remembered; sampled on
  // the falling edge, where the registered outputs have settled.
  always @(negedge clk) begin
    seen[disp.screen] = 1'b1;
    if (clear_maxmin === 1'b1) clears++;
    if (reboot === 1'b1) reboots++;
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic scr(input fpm_screen_t s);
    int n;
    n = 0;
    while (disp.screen !== s && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("screen", 32'(disp.screen), 32'(s));
  endtask : scr

  task automatic press(input int b);
    op_u.push(b, 8);
  endtask : press

  task automatic do_reset();
    @(negedge clk);
    resetn = 1'b0;
    repeat (6) @(negedge clk);
    chk("lamp", 32'(lamp_all_on), 32'h1);
    resetn = 1'b1;
  endtask : do_reset

  task automatic goto_mode(input logic [1:0] m);
    for (int i = 0; i < 4 && disp.mode_sel !== m; i++) press(DOWN);
  endtask : goto_mode

  task automatic enter_pass(input logic [15:0] v);
    int n;
    for (int i = 0; i < 4; i++) begin
      n = 0;
      while (disp.digits[15-4*i -: 4] !== v[15-4*i -: 4] && n < 11) begin
        press(DOWN);
        n++;
      end
      chk("digit", 32'(disp.digits[15-4*i -: 4]), 32'(v[15-4*i -: 4]));
      chk("digit_pos", 32'(disp.digit_pos), i);
      if (i < 3) press(RIGHT);
    end
    press(ENTER);
  endtask : enter_pass

  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    {error_present, pass_reset_en, pass_cfg_en, ct_den_one_amp} = 4'h0;
    password = 16'h1957;
    seen = '0;
    for (int e = 0; e < 2; e++) begin
      error_present = e[0];
      do_reset();
      scr(SCR_LAMP_SEG);
      scr(SCR_BUILD);
      if (e == 1) scr(SCR_ERROR);
      scr(SCR_READING);
    end
    error_present = 1'b0;
    chk("den", 32'(ct_den_amps), 32'h5);
    ct_den_one_amp = 1'b1;
    @(negedge clk);
    chk("den", 32'(ct_den_amps), 32'h1);
    chk("stored", 32'(cfg_stored), 32'({1'b1, 16'h0200, 2'h0}));
    chk("rating", 32'(ct_primary), 32'd200);
    p = 32'(param_sel);
    scr(SCR_BLANK);
    scr(SCR_READING);
    chk("param", 32'(param_sel), (p + 1) % 8);
    // Main menu rotation; the first down is held long to show a single event.
    press(MENU);
    scr(SCR_MAIN);
    chk("mode", 32'(disp.mode_sel), 32'h0);
    chk("flash", 32'(disp.flash_upper), 32'h1);
    for (int i = 1; i < 5; i++) begin
      op_u.push(DOWN, (i == 1) ? 30 : 8);
      chk("mode", 32'(disp.mode_sel), i % 4);
    end
    press(ENTER);
    scr(SCR_RST_NO);
    press(DOWN);
    scr(SCR_RST_NO);
    press(ENTER);
    scr(SCR_MAIN);
    chk("mode", 32'(disp.mode_sel), 32'h1);
    goto_mode(2'h0);
    press(ENTER);
    press(RIGHT);
    scr(SCR_RST_YES);
    seen = '0;
    press(ENTER);
    chk("done", 32'(seen[SCR_RST_DONE]), 32'h1);
    chk("clears", clears, 1);
    scr(SCR_READING);
    p = 32'(param_sel);
    repeat (30) @(negedge clk);
    chk("param", 32'(param_sel), p);
    // Protected reset: a wrong code first, then the right one.
    pass_reset_en = 1'b1;
    press(MENU);
    press(ENTER);
    press(RIGHT);
    press(ENTER);
    scr(SCR_PASS);
    chk("digit_pos", 32'(disp.digit_pos), 32'h0);
    chk("flash", 32'(disp.flash_digit), 32'h1);
    seen = '0;
    enter_pass(16'h1958);
    scr(SCR_RST_YES);
    chk("fail", 32'(seen[SCR_PASS_FAIL]), 32'h1);
    chk("clears", clears, 1);
    press(ENTER);
    seen = '0;
    enter_pass(16'h1957);
    chk("done", 32'(seen[SCR_RST_DONE]), 32'h1);
    chk("clears", clears, 2);
    scr(SCR_READING);
    pass_reset_en = 1'b0;
    // Configuration walk, edits, then a cancelled store.
    press(MENU);
    goto_mode(2'h1);
    press(ENTER);
    scr(SCR_CFG_LIST);
    for (int i = 1; i < 6; i++) begin
      press(DOWN);
      chk("cfg", 32'(disp.cfg_sel), i % 5);
    end
    press(ENTER);
    scr(SCR_SCROLL_SET);
    press(RIGHT);
    press(DOWN);
    press(RIGHT);
    press(ENTER);
    scr(SCR_CT_NUM);
    press(ENTER);
    press(DOWN);
    scr(SCR_CT_DEN);
    press(ENTER);
    scr(SCR_CT_MULT);
    press(DOWN);
    press(DOWN);
    press(MENU);
    press(MENU);
    scr(SCR_STORE_YES);
    press(RIGHT);
    scr(SCR_STORE_NO);
    press(ENTER);
    scr(SCR_MAIN);
    chk("stored", 32'(cfg_stored), 32'({1'b1, 16'h0200, 2'h0}));
    chk("reboots", reboots, 0);
    // With nothing edited, menu presses from the scroll setting step back out.
    press(ENTER);
    press(ENTER);
    scr(SCR_SCROLL_SET);
    press(MENU);
    chk("menu1", 32'(disp.screen), 32'(SCR_CFG_LIST));
    press(MENU);
    chk("menu2", 32'(disp.screen), 32'(SCR_MAIN));
    press(MENU);
    chk("menu3", 32'(disp.screen), 32'(SCR_READING));
    // Third reset in mid-run, then a protected edit that is saved.
    do_reset();
    scr(SCR_READING);
    pass_cfg_en = 1'b1;
    press(MENU);
    goto_mode(2'h1);
    press(ENTER);
    press(DOWN);
    press(ENTER);
    scr(SCR_CT_NUM);
    press(DOWN);
    scr(SCR_PASS);
    enter_pass(16'h1957);
    scr(SCR_CT_NUM);
    press(DOWN);
    press(ENTER);
    press(ENTER);
    press(DOWN);
    press(MENU);
    press(MENU);
    scr(SCR_STORE_YES);
    seen = '0;
    press(ENTER);
    scr(SCR_READING);
    chk("store_done", 32'(seen[SCR_STORE_DONE]), 32'h1);
    chk("relamp", 32'(seen[SCR_LAMP_LED]), 32'h1);
    chk("reboots", reboots, 1);
    chk("stored", 32'(cfg_stored), 32'({1'b1, 16'h1200, 2'h1}));
    chk("rating", 32'(ct_primary), 32'd12000);
    end_sim();
  end
endmodule : tb

bind fpm_ctrl fpm_ctrl_sva #(.SHOW_CYCLES(SHOW_CYCLES), .N_PARAMS(N_PARAMS)) sva_u (
  .clk(clk), .resetn(resetn), .disp(disp), .lamp_all_on(lamp_all_on), .param_sel(param_sel),
  .cfg_stored(cfg_stored), .ct_den_one_amp(ct_den_one_amp), .ct_den_amps(ct_den_amps),
  .ct_primary(ct_primary), .clear_maxmin(clear_maxmin), .reboot(reboot));
